//--- src/tic_pkg.sv
// Constants, register map and carrier types of the threshold input conditioner
package tic_pkg;

    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned TICK_MS      = 5;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned AC_EXTRA_MS  = 30;
    localparam int unsigned N_CH         = 8;
    localparam int unsigned VOLT_W       = 12;
    localparam int unsigned DLY_W        = 21;
    localparam int unsigned ELAP_W       = 22;
    localparam int unsigned CNT_W        = 32;
    localparam int unsigned ADDR_W       = 9;

    // Thresholds in 0.1 V units, delays in ms
    localparam logic [VOLT_W-1:0] ACT_RST = 12'h370;
    localparam logic [VOLT_W-1:0] REL_RST = 12'h258;
    localparam logic [VOLT_W-1:0] ACT_MIN = 12'h0a0;
    localparam logic [VOLT_W-1:0] REL_MIN = 12'h064;
    localparam logic [VOLT_W-1:0] THR_MAX = 12'h7d0;
    localparam logic [DLY_W-1:0]  DLY_MAX = 21'h1b7740;
    localparam logic [VOLT_W-1:0] AC_DIV  = 12'h00a;

    // Global registers
    localparam logic [ADDR_W-1:0] REG_EVENT = 9'h000;
    localparam logic [ADDR_W-1:0] REG_MASK  = 9'h004;
    localparam logic [ADDR_W-1:0] REG_STATE = 9'h008;
    localparam logic [ADDR_W-1:0] REG_LIVE  = 9'h00c;
    // Channel window: bit 8 set, channel in [7:5], register in [4:2]
    localparam int unsigned       CH_SEL_BIT = 8;
    localparam logic [2:0] CH_ACT   = 3'h0;
    localparam logic [2:0] CH_REL   = 3'h1;
    localparam logic [2:0] CH_CFG   = 3'h2;
    localparam logic [2:0] CH_ADLY  = 3'h3;
    localparam logic [2:0] CH_DDLY  = 3'h4;
    localparam logic [2:0] CH_COUNT = 3'h5;
    localparam logic [2:0] CH_VOLT  = 3'h6;
    localparam int unsigned CFG_NC_BIT = 0;
    localparam int unsigned CFG_AC_BIT = 1;

    typedef logic [N_CH-1:0][VOLT_W-1:0] tic_vbus_t;

    typedef struct packed {
        logic [VOLT_W-1:0] act;
        logic [VOLT_W-1:0] rel;
        logic              nc;
        logic              ac;
        logic [DLY_W-1:0]  adly;
        logic [DLY_W-1:0]  ddly;
    } tic_chcfg_t;

    typedef struct packed {
        logic              energ;
        logic              status;
        logic [ELAP_W-1:0] elap;
    } tic_chst_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tic_bus_t;

endpackage

//--- src/tic_tick.sv
// Program cycle divider: one-cycle enable every TICKS clock cycles
module tic_tick #(
    parameter int unsigned TICKS = tic_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    // Enable
    output logic      tick_out
);
    import tic_pkg::*;

    localparam int unsigned CW = (TICKS > 1) ? $clog2(TICKS) : 1;
    localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } tic_div_t;

    tic_div_t r;
    tic_div_t next_r;

    always_comb begin
        next_r      = r;
        next_r.tick = 1'b0;
        if (r.cnt == LAST) begin
            next_r.cnt  = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + CW'(1);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick_out = r.tick;
endmodule

//--- src/tic_cond.sv
// One channel's threshold, polarity and delay conditioning (combinational)
module tic_cond (
    // Settings and state
    input  wire tic_pkg::tic_chcfg_t          cfg_in,
    input  wire tic_pkg::tic_chst_t           st_in,
    // Sample
    input  wire logic [tic_pkg::VOLT_W-1:0]   volt_in,
    input  wire logic                         tick_in,
    // Result
    output tic_pkg::tic_chst_t                next_st_out
);
    import tic_pkg::*;

    logic [VOLT_W-1:0] eff_rel;
    logic              energ;
    logic              raw;
    logic [ELAP_W-1:0] target;

    always_comb begin
        eff_rel = cfg_in.ac ? VOLT_W'(cfg_in.act / AC_DIV) : cfg_in.rel;
        if (volt_in > cfg_in.act) begin
            energ = 1'b1;
        end else if (volt_in < eff_rel) begin
            energ = 1'b0;
        end else begin
            energ = st_in.energ;
        end
        raw = energ ^ cfg_in.nc;
        if (raw) begin
            target = ELAP_W'(cfg_in.adly);
        end else begin
            target = ELAP_W'(cfg_in.ddly) + (cfg_in.ac ? ELAP_W'(AC_EXTRA_MS) : '0);
        end
        next_st_out = st_in;
        if (tick_in) begin
            next_st_out.energ = energ;
            if (raw == st_in.status) begin
                next_st_out.elap = '0;
            end else if (st_in.elap >= target) begin
                next_st_out.status = raw;
                next_st_out.elap   = '0;
            end else begin
                next_st_out.elap = st_in.elap + ELAP_W'(TICK_MS);
            end
        end
    end
endmodule

//--- src/tic_top.sv
// Eight-channel threshold input conditioner with register port and interrupt
//
// The register offsets and the plain strobed port are this design's own decisions.
module tic_top #(
    parameter int unsigned TICK_CYCLES = tic_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                           mclk_in,
    input  wire logic                           rst_n_in,
    // Digitised channel voltages, 0.1 V units
    input  wire tic_pkg::tic_vbus_t             volt_in,
    // Register port
    input  wire logic [tic_pkg::ADDR_W-1:0]     addr_in,
    input  wire logic [31:0]                    wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic [31:0]                         rdata_out,
    // Conditioned states towards internal logic
    output logic [tic_pkg::N_CH-1:0]            state_out,
    // Interrupt
    output logic                                irq_out
);
    import tic_pkg::*;

    typedef struct packed {
        tic_chcfg_t [N_CH-1:0]             cfg;
        tic_chst_t  [N_CH-1:0]             st;
        logic       [N_CH-1:0][CNT_W-1:0]  cnt;
        logic       [N_CH-1:0]             out;
        logic       [N_CH-1:0]             evt;
        logic       [N_CH-1:0]             mask;
        logic       [31:0]                 rdata;
        logic                              irq;
    } tic_state_t;

    tic_state_t          r;
    tic_state_t          next_r;
    tic_chst_t [N_CH-1:0] cond_st;
    logic                tick;

    // Limits a written value to the documented setting range
    function automatic logic [31:0] clampv(input logic [31:0] v,
                                           input logic [31:0] lo,
                                           input logic [31:0] hi);
        logic [31:0] res;
        res = v;
        if (v < lo) begin
            res = lo;
        end else if (v > hi) begin
            res = hi;
        end
        return res;
    endfunction

    function automatic tic_chcfg_t cfg_default();
        tic_chcfg_t c;
        c      = '0;
        c.act  = ACT_RST;
        c.rel  = REL_RST;
        c.nc   = 1'b0;
        c.ac   = 1'b0;
        c.adly = '0;
        c.ddly = '0;
        return c;
    endfunction

    tic_tick #(
        .TICKS(TICK_CYCLES)
    ) u_tick (
        .mclk_in (mclk_in),
        .rst_n_in(rst_n_in),
        .tick_out(tick)
    );

    // One conditioner per channel, each fed only its own settings
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        tic_cond u_cond (
            .cfg_in     (r.cfg[g]),
            .st_in      (r.st[g]),
            .volt_in    (volt_in[g]),
            .tick_in    (tick),
            .next_st_out(cond_st[g])
        );
    end

    logic              ch_sel;
    logic [2:0]        ch_idx;
    logic [2:0]        ch_reg;
    logic [N_CH-1:0]   rise;
    logic [N_CH-1:0]   clr;
    logic [31:0]       rd_val;

    always_comb begin
        ch_sel = addr_in[CH_SEL_BIT];
        ch_idx = addr_in[7:5];
        ch_reg = addr_in[4:2];
    end

    // Status edges and clear commands for this cycle
    always_comb begin
        rise = '0;
        clr  = '0;
        for (int i = 0; i < N_CH; i++) begin
            rise[i] = cond_st[i].status && !r.st[i].status;
            if (wr_in && ch_sel && ch_idx == 3'(i) && ch_reg == CH_COUNT) begin
                clr[i] = 1'b1;
            end
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_val = '0;
        if (!ch_sel) begin
            unique case (addr_in)
                REG_EVENT: rd_val = 32'(r.evt);
                REG_MASK:  rd_val = 32'(r.mask);
                REG_STATE: rd_val = 32'(r.out);
                REG_LIVE: begin
                    for (int i = 0; i < N_CH; i++) begin
                        rd_val[i] = r.st[i].status;
                    end
                end
                default:   rd_val = '0;
            endcase
        end else begin
            unique case (ch_reg)
                CH_ACT:   rd_val = 32'(r.cfg[ch_idx].act);
                CH_REL:   rd_val = 32'(r.cfg[ch_idx].rel);
                CH_CFG: begin
                    rd_val[CFG_NC_BIT] = r.cfg[ch_idx].nc;
                    rd_val[CFG_AC_BIT] = r.cfg[ch_idx].ac;
                end
                CH_ADLY:  rd_val = 32'(r.cfg[ch_idx].adly);
                CH_DDLY:  rd_val = 32'(r.cfg[ch_idx].ddly);
                CH_COUNT: rd_val = r.cnt[ch_idx];
                CH_VOLT:  rd_val = 32'(volt_in[ch_idx]);
                default:  rd_val = '0;
            endcase
        end
    end

    always_comb begin
        next_r       = r;
        next_r.rdata = '0;
        next_r.st    = cond_st;

        // Consumers get last cycle's states, one program cycle behind
        if (tick) begin
            for (int i = 0; i < N_CH; i++) begin
                next_r.out[i] = r.st[i].status;
            end
        end

        // A rise in the clear cycle still counts, so it is not lost
        for (int i = 0; i < N_CH; i++) begin
            if (clr[i]) begin
                next_r.cnt[i] = rise[i] ? CNT_W'(1) : '0;
            end else if (rise[i]) begin
                next_r.cnt[i] = r.cnt[i] + CNT_W'(1);
            end
        end

        // Register writes
        if (wr_in) begin
            if (!ch_sel) begin
                if (addr_in == REG_EVENT) begin
                    next_r.evt = r.evt & ~wdata_in[N_CH-1:0];
                end else if (addr_in == REG_MASK) begin
                    next_r.mask = wdata_in[N_CH-1:0];
                end
            end else begin
                unique case (ch_reg)
                    CH_ACT: begin
                        next_r.cfg[ch_idx].act =
                            VOLT_W'(clampv(wdata_in, 32'(ACT_MIN), 32'(THR_MAX)));
                    end
                    CH_REL: begin
                        next_r.cfg[ch_idx].rel =
                            VOLT_W'(clampv(wdata_in, 32'(REL_MIN), 32'(THR_MAX)));
                    end
                    CH_CFG: begin
                        next_r.cfg[ch_idx].nc = wdata_in[CFG_NC_BIT];
                        next_r.cfg[ch_idx].ac = wdata_in[CFG_AC_BIT];
                    end
                    CH_ADLY: begin
                        next_r.cfg[ch_idx].adly =
                            DLY_W'(clampv(wdata_in, 32'h0, 32'(DLY_MAX)));
                    end
                    CH_DDLY: begin
                        next_r.cfg[ch_idx].ddly =
                            DLY_W'(clampv(wdata_in, 32'h0, 32'(DLY_MAX)));
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Sticky events: a new rise wins over a same-cycle clear
        next_r.evt = next_r.evt | rise;

        if (rd_in) begin
            next_r.rdata = rd_val;
        end

        next_r.irq = |(next_r.evt & next_r.mask);
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            r <= '0;
            for (int i = 0; i < N_CH; i++) begin
                r.cfg[i] <= cfg_default();
            end
        end else begin
            r <= next_r;
        end
    end

    assign rdata_out = r.rdata;
    assign state_out = r.out;
    assign irq_out   = r.irq;
endmodule

//--- dv/tic_top_properties.sv
// Port checker of the threshold input conditioner, bound to the top module
module tic_top_chk #(
    parameter int unsigned TICK_CYCLES = tic_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                       mclk_in,
    input  wire logic                       rst_n_in,
    // Voltages and register port
    input  wire tic_pkg::tic_vbus_t         volt_in,
    input  wire logic [tic_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [31:0]                wdata_in,
    input  wire logic                       wr_in,
    input  wire logic                       rd_in,
    input  wire logic [31:0]                rdata_out,
    // States and interrupt
    input  wire logic [tic_pkg::N_CH-1:0]   state_out,
    input  wire logic                       irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import tic_pkg::*;
    // Mirrors the program cycle divider, which restarts on every reset edge
    int unsigned cnt;
    logic        tk;
    assign tk = (cnt == TICK_CYCLES - 1);
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt <= 0;
        end else begin
            cnt <= tk ? 0 : cnt + 1;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0) else $error("read data outside read slot");
    // The tick enable is registered, so the state moves two edges after the divider reaches its last count
    a_state_on_tick: assert property ($changed(state_out) |-> $past(tk, 2)) else $error("state moved off tick");
    a_irq_rise_cause: assert property ($rose(irq_out) |-> $past(tk) || $past(tk, 2)
        || $past(wr_in && addr_in == REG_MASK, 2) || $past(wr_in && addr_in == REG_MASK))
        else $error("interrupt rose without cause");
    // A rise lands only where cnt is zero; one in the clear cycle legally keeps the bit
    a_irq_w1c_clear: assert property ((wr_in && addr_in == REG_EVENT && wdata_in[7:0] == 8'hff && cnt > 0
        && cnt < TICK_CYCLES - 3)
        |-> ##2 !irq_out) else $error("interrupt kept after clear");
    a_irq_mask_off: assert property ((wr_in && addr_in == REG_MASK && wdata_in[7:0] == 8'h00) |-> ##2 !irq_out[*3])
        else $error("interrupt kept while masked");
    a_read_state: assert property ((rd_in && addr_in == REG_STATE) |=> rdata_out == {24'h0, $past(state_out)})
        else $error("state read mismatch");
    a_reset_clean: assert property ($rose(rst_n_in) |-> state_out == 8'h00 && !irq_out && rdata_out == 32'h0)
        else $error("outputs not clean after reset");
    a_unmapped_zero: assert property ((rd_in && addr_in == 9'h010) |=> rdata_out == 32'h0) else $error("unmapped read");
    a_event_width: assert property ((rd_in && addr_in == REG_EVENT) |=> rdata_out[31:8] == 24'h0)
        else $error("event upper bits set");

    c_irq_rise: cover property ($rose(irq_out));
    c_state_rise: cover property ($rose(state_out[0]));
    c_state_read: cover property (rd_in && addr_in == REG_STATE);
endmodule

bind tic_top tic_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .volt_in(volt_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .state_out(state_out), .irq_out(irq_out));

//--- dv/tic_vsrc.sv
// Voltage front end model: holds one digitised level per channel
module tic_vsrc (
    // Clock and reset
    input  wire logic                       mclk_in,
    input  wire logic                       rst_n_in,
    // Level update request
    input  wire logic                       set_in,
    input  wire logic [2:0]                 ch_in,
    input  wire logic [tic_pkg::VOLT_W-1:0] v_in,
    // Digitised levels
    output tic_pkg::tic_vbus_t              volt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            volt_out <= '0;
        end else if (set_in) begin
            volt_out[ch_in] <= v_in;
        end
    end
endmodule

//--- dv/test_threshold_input_conditioner.sv
// Self-checking bench of the threshold input conditioner
module test_threshold_input_conditioner;
    timeunit 1ns;
    timeprecision 1ps;
    import tic_pkg::*;
    // Short program cycle keeps delay scenarios brief
    localparam int unsigned T = 10;
    logic               mclk_in;
    logic               rst_n_in;
    logic [ADDR_W-1:0]  addr_in;
    logic [31:0]        wdata_in;
    logic               wr_in;
    logic               rd_in;
    logic [31:0]        rdata_out;
    logic [N_CH-1:0]    state_out;
    logic               irq_out;
    tic_vbus_t          volt_in;
    logic               vs_set;
    logic [2:0]         vs_ch;
    logic [VOLT_W-1:0]  vs_v;
    int                 miscompares;
    int                 compares;
    int                 cycles;

    tic_top #(.TICK_CYCLES(T)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .volt_in(volt_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .state_out(state_out), .irq_out(irq_out));
    tic_vsrc vsrc_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .set_in(vs_set), .ch_in(vs_ch), .v_in(vs_v),
        .volt_out(volt_in));

    function automatic logic [8:0] ca(input int ch, input logic [2:0] r);
        return {1'b1, 3'(ch), r, 2'b00};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out & m, e);
    endtask
    task automatic setv(input int ch, input logic [VOLT_W-1:0] v);
        @(posedge mclk_in);
        vs_set <= 1'b1;
        vs_ch  <= 3'(ch);
        vs_v   <= v;
        @(posedge mclk_in);
        vs_set <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * T) @(posedge mclk_in);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk_in);
        #1;
        chk({31'h0, irq_out}, {31'h0, e});
    endtask

    task automatic t_defaults();
        for (int ch = 0; ch < 8; ch++) begin
            rd_chk(ca(ch, CH_ACT), {20'h0, ACT_RST});
            rd_chk(ca(ch, CH_REL), {20'h0, REL_RST});
            rd_chk(ca(ch, CH_CFG), 32'h0);
            rd_chk(ca(ch, CH_ADLY), 32'h0);
            rd_chk(ca(ch, CH_DDLY), 32'h0);
            rd_chk(ca(ch, CH_COUNT), 32'h0);
        end
        rd_chk(9'h010, 32'h0);
        rd_chk(REG_STATE, 32'h0);
    endtask
    task automatic t_open();
        wr(REG_MASK, 32'h1);
        setv(0, 12'h384);
        ticks(2);
        rd_chk(REG_LIVE, 32'h1, 32'h1);
        rd_chk(REG_EVENT, 32'h1, 32'h1);
        rd_chk(ca(0, CH_COUNT), 32'h1);
        irq_is(1'b1);
        ticks(1);
        rd_chk(REG_STATE, 32'h1, 32'h1);
        wr(REG_EVENT, 32'hff);
        irq_is(1'b0);
        setv(0, 12'h2bc);
        ticks(2);
        rd_chk(REG_LIVE, 32'h1, 32'h1);
        setv(0, 12'h1f4);
        ticks(2);
        rd_chk(REG_LIVE, 32'h0, 32'h1);
        wr(ca(0, CH_COUNT), 32'h0);
        rd_chk(ca(0, CH_COUNT), 32'h0);
        // Exactly at the threshold must not activate: comparison is strict
        setv(0, 12'h370);
        ticks(2);
        rd_chk(REG_LIVE, 32'h0, 32'h1);
        setv(0, 12'h371);
        ticks(2);
        rd_chk(REG_LIVE, 32'h1, 32'h1);
        rd_chk(ca(0, CH_COUNT), 32'h1);
        wr(REG_MASK, 32'h0);
        irq_is(1'b0);
    endtask
    task automatic t_closed();
        wr(ca(1, CH_CFG), 32'h1);
        ticks(2);
        rd_chk(REG_LIVE, 32'h2, 32'h2);
        setv(1, 12'h384);
        ticks(2);
        rd_chk(REG_LIVE, 32'h0, 32'h2);
    endtask
    task automatic t_delay();
        wr(ca(2, CH_ADLY), 32'h14);
        wr(ca(2, CH_DDLY), 32'h14);
        setv(2, 12'h384);
        ticks(3);
        rd_chk(REG_LIVE, 32'h0, 32'h4);
        ticks(3);
        rd_chk(REG_LIVE, 32'h4, 32'h4);
        setv(2, 12'h000);
        ticks(3);
        rd_chk(REG_LIVE, 32'h4, 32'h4);
        ticks(3);
        rd_chk(REG_LIVE, 32'h0, 32'h4);
    endtask
    task automatic t_ac();
        wr(ca(3, CH_CFG), 32'h2);
        setv(3, 12'h384);
        ticks(2);
        rd_chk(REG_LIVE, 32'h8, 32'h8);
        setv(3, 12'h064);
        // Long enough that the user release level plus the AC delay would already have dropped it
        ticks(8);
        rd_chk(REG_LIVE, 32'h8, 32'h8);
        setv(3, 12'h032);
        ticks(5);
        rd_chk(REG_LIVE, 32'h8, 32'h8);
        ticks(4);
        rd_chk(REG_LIVE, 32'h0, 32'h8);
    endtask
    task automatic t_indep();
        wr(ca(4, CH_ACT), 32'h100);
        rd_chk(ca(4, CH_ACT), 32'h100);
        rd_chk(ca(5, CH_ACT), {20'h0, ACT_RST});
        setv(4, 12'h12c);
        setv(5, 12'h12c);
        rd_chk(ca(4, CH_VOLT), 32'h12c);
        ticks(2);
        rd_chk(REG_LIVE, 32'h10, 32'h30);
    endtask
    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // Ceiling well above the expected run of about seven hundred cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    initial begin
        rst_n_in = 1'b0;
        addr_in  = '0;
        wdata_in = 32'h0;
        wr_in    = 1'b0;
        rd_in    = 1'b0;
        vs_set   = 1'b0;
        vs_ch    = 3'h0;
        vs_v     = '0;
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        t_defaults();
        t_open();
        t_closed();
        t_delay();
        t_ac();
        t_indep();
        print_verdict();
    end
endmodule
